// file: logic/bfsr_pkg.sv
// constants and types shared by the bus reading formatter and service request logic
package bfsr_pkg;
  // output formats, selected by the format command argument
  localparam logic [2:0] FMT_SINGLE_WITH_PREFIX = 3'h0;
  localparam logic [2:0] FMT_SINGLE_BARE = 3'h1;
  localparam logic [2:0] FMT_BUFFER_PREFIX_LOCATION = 3'h2;
  localparam logic [2:0] FMT_BUFFER_LOCATION_ONLY = 3'h3;
  localparam logic [2:0] FMT_BUFFER_PREFIX_ONLY = 3'h4;
  localparam logic [2:0] FMT_BUFFER_BARE = 3'h5;
  localparam logic [2:0] FMT_DEFAULT = FMT_SINGLE_WITH_PREFIX;
  // data source select
  localparam logic SOURCE_CONVERTER = 1'b0;
  localparam logic SOURCE_BUFFER = 1'b1;
  localparam logic SOURCE_DEFAULT = SOURCE_CONVERTER;
  // status byte bit positions and mask weights share positions
  localparam int ST_OVERFLOW = 0;
  localparam int ST_STORE_FULL = 1;
  localparam int ST_STORE_HALF = 2;
  localparam int ST_READING_DONE = 3;
  localparam int ST_READY = 4;
  localparam int ST_ERROR = 5;
  localparam int COND_W = 6;
  localparam logic [COND_W-1:0] MASK_RESET = 6'h00;
  // ascii characters
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_EXP = 8'h45;
  localparam logic [7:0] CH_TAG = 8'h42;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_TERM0 = 8'h0d;
  localparam logic [7:0] CH_TERM1 = 8'h0a;
  // character positions within one reading field
  localparam logic [4:0] POS_PREFIX0 = 5'h00;
  localparam logic [4:0] POS_PREFIX3 = 5'h03;
  localparam logic [4:0] POS_SIGN = 5'h04;
  localparam logic [4:0] POS_LEAD = 5'h05;
  localparam logic [4:0] POS_DOT = 5'h06;
  localparam logic [4:0] POS_FRAC5 = 5'h0c;
  localparam logic [4:0] POS_EXP_CH = 5'h0d;
  localparam logic [4:0] POS_EXP_SIGN = 5'h0e;
  localparam logic [4:0] POS_EXP_DIG = 5'h0f;
  localparam logic [4:0] POS_LOC_COMMA = 5'h10;
  localparam logic [4:0] POS_LOC_TAG = 5'h11;
  localparam logic [4:0] POS_LOC_D2 = 5'h12;
  localparam logic [4:0] POS_LOC_D0 = 5'h14;
  localparam logic [4:0] POS_SEP = 5'h15;
  localparam logic [4:0] POS_TERM0 = 5'h16;
  localparam logic [4:0] POS_TERM1 = 5'h17;
  localparam logic [11:0] LOC_FIRST = 12'h001;
  // one reading: sign, seven bcd mantissa digits (6 is leading), signed one digit exponent
  typedef struct packed {
    logic neg;
    logic [6:0][3:0] mant;
    logic exp_neg;
    logic [3:0] exp;
  } bfsr_reading_t;
endpackage

// file: logic/bfsr_stream_if.sv
// valid/ready character stream between the formatter and its output fifo
`timescale 1ns/1ps
interface bfsr_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: logic/bfsr_fifo.sv
// output character fifo with a registered read stage; depth must be a power of two
`timescale 1ns/1ps
module bfsr_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  bfsr_stream_if.snk wr,
  output logic [W-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic [W-1:0] out_r, out_nxt;
  logic ov_r, ov_nxt;
  logic push, pop;

  // full stalls the formatter, the output stage refills whenever it empties
  assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
  assign push = wr.valid && wr.ready;
  assign pop = (cnt_r != '0) && (!ov_r || i_ready);
  assign o_data = out_r;
  assign o_valid = ov_r;

  // pointer, count and output stage next values
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    out_nxt = pop ? mem[rp_r] : out_r;
    ov_nxt = pop ? 1'b1 : (i_ready ? 1'b0 : ov_r);
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      out_r <= '0;
      ov_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
      ov_r <= ov_nxt;
    end
  end

  // storage array
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end
endmodule

// file: logic/bfsr_status.sv
// service request mask, sticky condition bits, frozen status byte and poll answer
`timescale 1ns/1ps
module bfsr_status (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_dev_clear,
  input wire logic i_mask_wr,
  input wire logic [7:0] i_mask_val,
  input wire logic [bfsr_pkg::COND_W-1:0] i_cond,
  input wire logic i_serial_poll,
  output logic [7:0] o_poll_byte,
  output logic o_poll_valid,
  output logic o_srq
);
  localparam int CW = bfsr_pkg::COND_W;
  logic [CW-1:0] cond_r, cond_nxt, mask_r, mask_nxt;
  logic [CW-1:0] snap_r, snap_nxt;
  logic srq_r, srq_nxt, pv_r, pv_nxt;
  logic [7:0] pb_r, pb_nxt;
  logic raise;

  assign o_srq = srq_r;
  assign o_poll_byte = pb_r;
  assign o_poll_valid = pv_r;

  // next values of mask, conditions, request and poll answer
  always_comb begin
    mask_nxt = mask_r;
    if (i_dev_clear) begin
      mask_nxt = bfsr_pkg::MASK_RESET;
    end else if (i_mask_wr) begin
      mask_nxt = i_mask_val[CW-1:0];
    end
    cond_nxt = (cond_r & ~{CW{i_serial_poll}}) | i_cond;
    raise = |(i_cond & mask_r & (~cond_r | {CW{i_serial_poll}})) && (!srq_r || i_serial_poll);
    srq_nxt = srq_r;
    snap_nxt = snap_r;
    if (i_dev_clear) begin
      srq_nxt = 1'b0;
    end else if (raise) begin
      srq_nxt = 1'b1;
      snap_nxt = cond_nxt;
    end else if (i_serial_poll) begin
      srq_nxt = 1'b0;
    end
    pv_nxt = i_serial_poll;
    pb_nxt = pb_r;
    if (i_serial_poll) begin
      pb_nxt = srq_r ? {1'b0, 1'b1, snap_r} : {1'b0, 1'b0, cond_r};
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mask_r <= bfsr_pkg::MASK_RESET;
      cond_r <= '0;
      snap_r <= '0;
      srq_r <= 1'b0;
      pv_r <= 1'b0;
      pb_r <= 8'h00;
    end else begin
      mask_r <= mask_nxt;
      cond_r <= cond_nxt;
      snap_r <= snap_nxt;
      srq_r <= srq_nxt;
      pv_r <= pv_nxt;
      pb_r <= pb_nxt;
    end
  end
endmodule

// file: logic/bfsr_talker.sv
// bus talker: ascii reading formatter, output fifo and service request status
// What this block does
// - mode 0 sends one reading per talk with prefix; buffer reading adds ",B" location.
// - mode 1 sends one reading per talk bare; buffer reading adds comma and number.
// - mode 2 sends whole buffer comma separated with prefixes and tagged locations.
// - mode 3 sends whole buffer comma separated, no prefixes, location numbers kept.
// - mode 4 sends whole buffer comma separated with prefixes, no locations.
// - mode 5 sends whole buffer comma separated as bare values.
// - power-up and device clear restore the default output format.
// - source select picks converter reading or buffer readings.
// - terminator and end flag after each single reading, once after buffer end.
// - whole-buffer format with converter source sends no terminator.
// - power-up and device clear clear the mask, disabling service requests.
// - mask loads from summed weights; zero clears all bits.
// - weights 1 overflow, 2 full, 4 half, 8 done, 16 ready, 32 error.
// - status bit 0 set on overrange input.
// - bit 1 set when store full, bit 2 when half full.
// - bit 3 set when conversion finishes.
// - bit 4 set only once all commands are executed and bus ready.
// - bit 5 set on any listed error condition.
// - bit 6 set when service requested, cleared by reading the status byte.
// - bit 7 always reads zero.
// - status byte frozen when a service request is raised.
`timescale 1ns/1ps
module bfsr_talker #(
  parameter int FIFO_DEPTH = 32,
  parameter int BUF_AW = 9
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_dev_clear,
  input wire logic i_fmt_wr,
  input wire logic [2:0] i_fmt_mode,
  input wire logic i_src_wr,
  input wire logic i_src_sel,
  input wire logic i_mask_wr,
  input wire logic [7:0] i_mask_val,
  input wire logic [3:0][7:0] i_prefix,
  input wire bfsr_pkg::bfsr_reading_t i_conv_reading,
  input wire logic i_talk_start,
  output logic o_busy,
  output logic o_buf_rd,
  output logic [BUF_AW-1:0] o_buf_addr,
  input wire bfsr_pkg::bfsr_reading_t i_buf_reading,
  input wire logic [BUF_AW:0] i_buf_count,
  output logic [7:0] o_talk_char,
  output logic o_talk_eoi,
  output logic o_talk_valid,
  input wire logic i_talk_ready,
  input wire logic i_overrange,
  input wire logic i_store_full,
  input wire logic i_store_half,
  input wire logic i_reading_done,
  input wire logic i_ready,
  input wire logic i_error,
  input wire logic i_serial_poll,
  output logic [7:0] o_poll_byte,
  output logic o_poll_valid,
  output logic o_srq
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_EMIT} bfsr_state_t;

  bfsr_state_t state_r, state_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic src_r, src_nxt;
  logic [4:0] pos_r, pos_nxt;
  bfsr_pkg::bfsr_reading_t rd_r, rd_nxt;
  logic [BUF_AW-1:0] idx_r, idx_nxt, sidx_r, sidx_nxt;
  logic [11:0] loc_r, loc_nxt, sloc_r, sloc_nxt;
  logic whole_r, whole_nxt, term_r, term_nxt, frombuf_r, frombuf_nxt;
  logic [BUF_AW:0] idx_inc;
  logic last_entry, active;
  logic [7:0] ch;
  logic [bfsr_pkg::COND_W-1:0] cond;
  logic [8:0] fifo_q;

  bfsr_stream_if #(.W(9)) st ();

  // which formats carry function prefixes
  function automatic logic prefix_on(input logic [2:0] m);
    return m == bfsr_pkg::FMT_SINGLE_WITH_PREFIX || m == bfsr_pkg::FMT_BUFFER_PREFIX_LOCATION
        || m == bfsr_pkg::FMT_BUFFER_PREFIX_ONLY;
  endfunction

  // which formats carry a buffer location field
  function automatic logic loc_on(input logic [2:0] m);
    return m == bfsr_pkg::FMT_SINGLE_WITH_PREFIX || m == bfsr_pkg::FMT_SINGLE_BARE
        || m == bfsr_pkg::FMT_BUFFER_PREFIX_LOCATION || m == bfsr_pkg::FMT_BUFFER_LOCATION_ONLY;
  endfunction

  // which formats put the letter tag before the location number
  function automatic logic tag_on(input logic [2:0] m);
    return m == bfsr_pkg::FMT_SINGLE_WITH_PREFIX || m == bfsr_pkg::FMT_BUFFER_PREFIX_LOCATION;
  endfunction

  // whole-buffer formats
  function automatic logic is_whole(input logic [2:0] m);
    return m == bfsr_pkg::FMT_BUFFER_PREFIX_LOCATION || m == bfsr_pkg::FMT_BUFFER_LOCATION_ONLY
        || m == bfsr_pkg::FMT_BUFFER_PREFIX_ONLY || m == bfsr_pkg::FMT_BUFFER_BARE;
  endfunction

  // three digit bcd increment of a location number
  function automatic logic [11:0] bcd_inc(input logic [11:0] v);
    logic [11:0] r;
    r = v;
    if (r[3:0] == 4'h9) begin
      r[3:0] = 4'h0;
      if (r[7:4] == 4'h9) begin
        r[7:4] = 4'h0;
        r[11:8] = (r[11:8] == 4'h9) ? 4'h0 : r[11:8] + 4'h1;
      end else begin
        r[7:4] = r[7:4] + 4'h1;
      end
    end else begin
      r[3:0] = r[3:0] + 4'h1;
    end
    return r;
  endfunction

  function automatic logic [7:0] digit(input logic [3:0] d);
    return bfsr_pkg::CH_ZERO + {4'h0, d};
  endfunction

  assign idx_inc = {1'b0, idx_r} + {{BUF_AW{1'b0}}, 1'b1};
  assign last_entry = !whole_r || (idx_inc == i_buf_count);
  assign o_busy = (state_r != ST_IDLE);
  assign o_buf_addr = idx_r;

  // character for the current position of the field
  always_comb begin
    ch = bfsr_pkg::CH_TERM1;
    if (pos_r <= bfsr_pkg::POS_PREFIX3) begin
      ch = i_prefix[~pos_r[1:0]];
    end else if (pos_r == bfsr_pkg::POS_SIGN) begin
      ch = rd_r.neg ? bfsr_pkg::CH_MINUS : bfsr_pkg::CH_PLUS;
    end else if (pos_r == bfsr_pkg::POS_LEAD) begin
      ch = digit(rd_r.mant[6]);
    end else if (pos_r == bfsr_pkg::POS_DOT) begin
      ch = bfsr_pkg::CH_DOT;
    end else if (pos_r <= bfsr_pkg::POS_FRAC5) begin
      ch = digit(rd_r.mant[3'(bfsr_pkg::POS_FRAC5 - pos_r)]);
    end else if (pos_r == bfsr_pkg::POS_EXP_CH) begin
      ch = bfsr_pkg::CH_EXP;
    end else if (pos_r == bfsr_pkg::POS_EXP_SIGN) begin
      ch = rd_r.exp_neg ? bfsr_pkg::CH_MINUS : bfsr_pkg::CH_PLUS;
    end else if (pos_r == bfsr_pkg::POS_EXP_DIG) begin
      ch = digit(rd_r.exp);
    end else if (pos_r == bfsr_pkg::POS_LOC_COMMA || pos_r == bfsr_pkg::POS_SEP) begin
      ch = bfsr_pkg::CH_COMMA;
    end else if (pos_r == bfsr_pkg::POS_LOC_TAG) begin
      ch = bfsr_pkg::CH_TAG;
    end else if (pos_r <= bfsr_pkg::POS_LOC_D0) begin
      ch = digit(loc_r[4 * (2'(bfsr_pkg::POS_LOC_D0 - pos_r)) +: 4]);
    end else if (pos_r == bfsr_pkg::POS_TERM0) begin
      ch = bfsr_pkg::CH_TERM0;
    end
  end

  // whether the current position is sent in this format
  always_comb begin
    active = 1'b1;
    if (pos_r <= bfsr_pkg::POS_PREFIX3) begin
      active = prefix_on(mode_r);
    end else if (pos_r == bfsr_pkg::POS_LOC_COMMA
        || (pos_r >= bfsr_pkg::POS_LOC_D2 && pos_r <= bfsr_pkg::POS_LOC_D0)) begin
      active = frombuf_r && loc_on(mode_r);
    end else if (pos_r == bfsr_pkg::POS_LOC_TAG) begin
      active = frombuf_r && tag_on(mode_r);
    end else if (pos_r == bfsr_pkg::POS_SEP) begin
      active = whole_r && !last_entry;
    end else if (pos_r >= bfsr_pkg::POS_TERM0) begin
      active = term_r && last_entry;
    end
  end

  assign st.valid = (state_r == ST_EMIT) && active;
  assign st.data = {pos_r == bfsr_pkg::POS_TERM1, ch};

  // format, source and talk sequence next values
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    src_nxt = src_r;
    pos_nxt = pos_r;
    rd_nxt = rd_r;
    idx_nxt = idx_r;
    loc_nxt = loc_r;
    sidx_nxt = sidx_r;
    sloc_nxt = sloc_r;
    whole_nxt = whole_r;
    term_nxt = term_r;
    frombuf_nxt = frombuf_r;
    o_buf_rd = 1'b0;
    if (i_dev_clear) begin
      mode_nxt = bfsr_pkg::FMT_DEFAULT;
      src_nxt = bfsr_pkg::SOURCE_DEFAULT;
    end else begin
      if (i_fmt_wr && i_fmt_mode <= bfsr_pkg::FMT_BUFFER_BARE) begin
        mode_nxt = i_fmt_mode;
      end
      if (i_src_wr) begin
        src_nxt = i_src_sel;
      end
    end
    if (i_buf_count == '0) begin
      sidx_nxt = '0;
      sloc_nxt = bfsr_pkg::LOC_FIRST;
    end
    case (state_r)
      ST_IDLE: begin
        if (i_talk_start) begin
          pos_nxt = bfsr_pkg::POS_PREFIX0;
          whole_nxt = 1'b0;
          term_nxt = 1'b1;
          if (src_r == bfsr_pkg::SOURCE_BUFFER) begin
            if (i_buf_count != '0) begin
              frombuf_nxt = 1'b1;
              whole_nxt = is_whole(mode_r);
              idx_nxt = is_whole(mode_r) ? '0 : sidx_r;
              loc_nxt = is_whole(mode_r) ? bfsr_pkg::LOC_FIRST : sloc_r;
              state_nxt = ST_FETCH;
            end
          end else begin
            frombuf_nxt = 1'b0;
            rd_nxt = i_conv_reading;
            term_nxt = !is_whole(mode_r);
            state_nxt = ST_EMIT;
          end
        end
      end
      ST_FETCH: begin
        o_buf_rd = 1'b1;
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        rd_nxt = i_buf_reading;
        state_nxt = ST_EMIT;
      end
      ST_EMIT: begin
        if (!active || st.ready) begin
          if (pos_r != bfsr_pkg::POS_TERM1) begin
            pos_nxt = pos_r + 5'h01;
          end else if (!last_entry) begin
            idx_nxt = idx_inc[BUF_AW-1:0];
            loc_nxt = bcd_inc(loc_r);
            pos_nxt = bfsr_pkg::POS_PREFIX0;
            state_nxt = ST_FETCH;
          end else begin
            state_nxt = ST_IDLE;
            if (frombuf_r && !whole_r) begin
              sidx_nxt = (idx_inc >= i_buf_count) ? '0 : idx_inc[BUF_AW-1:0];
              sloc_nxt = (idx_inc >= i_buf_count) ? bfsr_pkg::LOC_FIRST : bcd_inc(loc_r);
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
      mode_r <= bfsr_pkg::FMT_DEFAULT;
      src_r <= bfsr_pkg::SOURCE_DEFAULT;
      pos_r <= bfsr_pkg::POS_PREFIX0;
      rd_r <= '0;
      idx_r <= '0;
      loc_r <= bfsr_pkg::LOC_FIRST;
      sidx_r <= '0;
      sloc_r <= bfsr_pkg::LOC_FIRST;
      whole_r <= 1'b0;
      term_r <= 1'b0;
      frombuf_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      src_r <= src_nxt;
      pos_r <= pos_nxt;
      rd_r <= rd_nxt;
      idx_r <= idx_nxt;
      loc_r <= loc_nxt;
      sidx_r <= sidx_nxt;
      sloc_r <= sloc_nxt;
      whole_r <= whole_nxt;
      term_r <= term_nxt;
      frombuf_r <= frombuf_nxt;
    end
  end

  // output character fifo toward the bus handshake
  bfsr_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .wr(st),
    .o_data(fifo_q),
    .o_valid(o_talk_valid),
    .i_ready(i_talk_ready)
  );
  assign o_talk_char = fifo_q[7:0];
  assign o_talk_eoi = fifo_q[8];

  // condition events into status byte positions
  assign cond[bfsr_pkg::ST_OVERFLOW] = i_overrange;
  assign cond[bfsr_pkg::ST_STORE_FULL] = i_store_full;
  assign cond[bfsr_pkg::ST_STORE_HALF] = i_store_half;
  assign cond[bfsr_pkg::ST_READING_DONE] = i_reading_done;
  assign cond[bfsr_pkg::ST_READY] = i_ready;
  assign cond[bfsr_pkg::ST_ERROR] = i_error;

  bfsr_status u_status (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_dev_clear(i_dev_clear),
    .i_mask_wr(i_mask_wr),
    .i_mask_val(i_mask_val),
    .i_cond(cond),
    .i_serial_poll(i_serial_poll),
    .o_poll_byte(o_poll_byte),
    .o_poll_valid(o_poll_valid),
    .o_srq(o_srq)
  );
endmodule

// file: dv/bfsr_talker_assertions.sv
// checker on the talker ports: status byte, service request and stream framing
`timescale 1ns/1ps
module bfsr_talker_assertions (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_dev_clear,
  input wire logic i_mask_wr,
  input wire logic [7:0] i_mask_val,
  input wire logic i_overrange,
  input wire logic i_store_full,
  input wire logic i_store_half,
  input wire logic i_reading_done,
  input wire logic i_ready,
  input wire logic i_error,
  input wire logic i_serial_poll,
  input wire logic [7:0] o_poll_byte,
  input wire logic o_poll_valid,
  input wire logic o_srq,
  input wire logic o_busy,
  input wire logic o_buf_rd,
  input wire logic [7:0] o_talk_char,
  input wire logic o_talk_eoi,
  input wire logic o_talk_valid
);
  logic [5:0] cond;
  logic [5:0] mask_r;
  logic [5:0] mask_nxt;
  logic [5:0] cond_r;
  logic clean_r;
  logic clean_nxt;
  assign cond = {i_error, i_ready, i_reading_done, i_store_half, i_store_full, i_overrange};
  // shadow mask and a flag for all sticky bits known clear
  always_comb begin
    mask_nxt = mask_r;
    clean_nxt = clean_r;
    if (i_sys_rst || i_dev_clear) mask_nxt = 6'h00;
    else if (i_mask_wr) mask_nxt = i_mask_val[5:0];
    if (i_sys_rst) clean_nxt = 1'b1;
    else if (cond != 6'h00) clean_nxt = 1'b0;
    else if (o_poll_valid && cond_r == 6'h00) clean_nxt = 1'b1;
  end
  // shadow registers
  always_ff @(posedge i_clk) begin
    mask_r <= mask_nxt;
    clean_r <= clean_nxt;
    cond_r <= cond;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_bit7_zero: assert property (o_poll_byte[7] == 1'b0)
    else $error("poll byte bit 7 set");
  a_poll_answer: assert property (i_serial_poll && o_srq |=> o_poll_valid && o_poll_byte[6])
    else $error("poll during request lacks request bit");
  a_poll_release: assert property (i_serial_poll && o_srq && cond == 6'h00 |=> !o_srq)
    else $error("request line not released by poll");
  a_clear_drops: assert property (i_dev_clear |=> !o_srq)
    else $error("request survives device clear");
  a_srq_holds: assert property (o_srq && !i_serial_poll && !i_dev_clear |=> o_srq)
    else $error("request dropped without poll");
  a_zero_mask: assert property (mask_r == 6'h00 && !o_srq |=> !o_srq)
    else $error("request raised with empty mask");
  a_enabled_raise: assert property (
    clean_r && !o_srq && (cond & mask_r) != 6'h00 && !i_dev_clear |=> o_srq)
    else $error("enabled condition raised no request");
  a_eoi_is_lf: assert property (o_talk_valid && o_talk_eoi |-> o_talk_char == bfsr_pkg::CH_TERM1)
    else $error("end flag not on line feed");
  a_buf_pulse: assert property (o_buf_rd |-> o_busy ##1 !o_buf_rd)
    else $error("buffer read not a single pulse");
  c_poll: cover property (o_srq && i_serial_poll);
  c_eoi: cover property (o_talk_valid && o_talk_eoi);
  c_fetch: cover property (o_buf_rd);
endmodule
bind bfsr_talker bfsr_talker_assertions u_chk (.i_clk, .i_sys_rst, .i_dev_clear, .i_mask_wr,
  .i_mask_val, .i_overrange, .i_store_full, .i_store_half, .i_reading_done, .i_ready, .i_error,
  .i_serial_poll, .o_poll_byte, .o_poll_valid, .o_srq, .o_busy, .o_buf_rd, .o_talk_char,
  .o_talk_eoi, .o_talk_valid);

// file: dv/bfsr_ctrl_model.sv
// bus controller model: takes talker bytes, slow every fourth cycle, can hold off fully
`timescale 1ns/1ps
module bfsr_ctrl_model (
  input wire logic i_clk,
  input wire logic [7:0] i_char,
  input wire logic i_eoi,
  input wire logic i_valid,
  input wire logic i_hold,
  output logic o_ready
);
  logic [1:0] cyc_r = 2'h0;
  logic [8:0] got_q[$];
  // ready pattern and capture of every accepted byte with its end flag
  always @(posedge i_clk) begin
    cyc_r <= cyc_r + 2'h1;
    o_ready <= !i_hold && cyc_r != 2'h3;
    if (i_valid && o_ready) got_q.push_back({i_eoi, i_char});
  end
endmodule

// file: dv/bfsr_talker_test.sv
// bench for the talker: format rows, fifo stall, status byte and service request
`timescale 1ns/1ps
module bfsr_talker_test;
  logic clk = 0, rst = 1, dclr = 0, fwr = 0, swr = 0, src = 0, mwr = 0, start = 0, poll = 0;
  logic hold = 0, busy, buf_rd, tv, teoi, tready, pvalid, srq;
  logic [2:0] fmode = 3'h0;
  logic [7:0] mval = 8'h00, pb, tch, pbyte;
  logic [5:0] cond = 6'h00;
  logic [8:0] baddr;
  logic [3:0][7:0] pre = {8'h46, 8'h55, 8'h4e, 8'h43};
  bfsr_pkg::bfsr_reading_t conv, bufr;
  logic [8:0] exp_q[$];
  logic [3:0] rows[10] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'h0, 4'h1, 4'h2, 4'h5};
  int num_errors = 0, samples_checked = 0, ptr = 0, n, q;
  bfsr_talker uut (.i_clk(clk), .i_sys_rst(rst), .i_dev_clear(dclr), .i_fmt_wr(fwr),
    .i_fmt_mode(fmode), .i_src_wr(swr), .i_src_sel(src), .i_mask_wr(mwr), .i_mask_val(mval),
    .i_prefix(pre), .i_conv_reading(conv), .i_talk_start(start), .o_busy(busy),
    .o_buf_rd(buf_rd), .o_buf_addr(baddr), .i_buf_reading(bufr), .i_buf_count(10'h003),
    .o_talk_char(tch), .o_talk_eoi(teoi), .o_talk_valid(tv), .i_talk_ready(tready),
    .i_overrange(cond[0]), .i_store_full(cond[1]), .i_store_half(cond[2]),
    .i_reading_done(cond[3]), .i_ready(cond[4]), .i_error(cond[5]), .i_serial_poll(poll),
    .o_poll_byte(pbyte), .o_poll_valid(pvalid), .o_srq(srq));
  bfsr_ctrl_model m (.i_clk(clk), .i_char(tch), .i_eoi(teoi), .i_valid(tv), .i_hold(hold),
    .o_ready(tready));
  // clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // reading store answers one cycle after each fetch
  always @(posedge clk) if (buf_rd) bufr <= rd(int'(baddr));
  function automatic bfsr_pkg::bfsr_reading_t rd(input int i);
    bfsr_pkg::bfsr_reading_t r;
    r.neg = i[0];
    r.exp_neg = ~i[0];
    r.exp = 4'(i);
    for (int j = 0; j < 7; j++) r.mant[j] = 4'((i + j) % 10);
    return r;
  endfunction
  task automatic put(input logic [7:0] c);
    exp_q.push_back({1'b0, c});
  endtask
  // expected characters of one reading field
  task automatic field(input bfsr_pkg::bfsr_reading_t r, input bit p, input bit l, input bit t,
    input int k);
    if (p) for (int j = 3; j >= 0; j--) put(pre[j]);
    put(r.neg ? bfsr_pkg::CH_MINUS : bfsr_pkg::CH_PLUS);
    put(bfsr_pkg::CH_ZERO + 8'(r.mant[6]));
    put(bfsr_pkg::CH_DOT);
    for (int j = 5; j >= 0; j--) put(bfsr_pkg::CH_ZERO + 8'(r.mant[j]));
    put(bfsr_pkg::CH_EXP);
    put(r.exp_neg ? bfsr_pkg::CH_MINUS : bfsr_pkg::CH_PLUS);
    put(bfsr_pkg::CH_ZERO + 8'(r.exp));
    if (l) begin
      put(bfsr_pkg::CH_COMMA);
      if (t) put(bfsr_pkg::CH_TAG);
      put(bfsr_pkg::CH_ZERO);
      put(bfsr_pkg::CH_ZERO);
      put(bfsr_pkg::CH_ZERO + 8'(k + 1));
    end
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // one talk cycle: row holds source in bit 3 and format below, h stalls, w writes setup
  task automatic run(input logic [3:0] row, input bit h, input bit w);
    bit wh;
    wh = row[2:0] >= 3'h2;
    exp_q.delete();
    m.got_q.delete();
    if (row[3] && !wh) begin
      field(rd(ptr), !row[0], 1, row[2:0] == 3'h0, ptr);
      ptr = (ptr + 1) % 3;
    end else if (row[3]) begin
      for (int k = 0; k < 3; k++) begin
        field(rd(k), !row[0], row[2:0] < 3'h4, row[2:0] == 3'h2, k);
        if (k < 2) put(bfsr_pkg::CH_COMMA);
      end
    end else field(conv, !row[0], 0, 0, 0);
    if (row[3] || !wh) begin
      put(bfsr_pkg::CH_TERM0);
      exp_q.push_back({1'b1, bfsr_pkg::CH_TERM1});
    end
    @(posedge clk);
    fwr <= w;
    swr <= w;
    fmode <= row[2:0];
    src <= row[3];
    hold <= h;
    @(posedge clk);
    fwr <= 0;
    swr <= 0;
    start <= 1;
    @(posedge clk);
    start <= 0;
    if (h) begin
      tick(150);
      check(16'(busy), 16'h1);
      @(posedge clk);
      hold <= 0;
    end
    q = 0;
    for (n = 0; n < 3000 && q < 4; n++) begin
      tick(1);
      q = (!busy && !tv) ? q + 1 : 0;
    end
    if (q < 4) begin
      num_errors++;
      complete_run();
    end
    check(16'(m.got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) check(16'(m.got_q[i]), 16'(exp_q[i]));
    $display("talk mode %0d source %0d done", row[2:0], row[3]);
  endtask
  task automatic do_poll;
    @(posedge clk);
    poll <= 1;
    @(posedge clk);
    poll <= 0;
    for (n = 0; n < 4; n++) begin
      #1;
      if (pvalid === 1'b1) break;
      @(posedge clk);
    end
    if (n == 4) begin
      num_errors++;
      complete_run();
    end
    pb = pbyte;
    tick(2);
  endtask
  task automatic ev(input logic [5:0] v);
    @(posedge clk);
    cond <= v;
    @(posedge clk);
    cond <= 6'h00;
    tick(3);
  endtask
  task automatic mw(input logic [7:0] v);
    @(posedge clk);
    mwr <= 1;
    mval <= v;
    @(posedge clk);
    mwr <= 0;
  endtask
  // main sequence
  initial begin
    conv = rd(7);
    repeat (5) @(posedge clk);
    rst <= 0;
    tick(1);
    check(16'({srq, busy, tv, pvalid, pbyte}), 16'h0);
    $display("reset test done");
    foreach (rows[i]) run(rows[i], 0, 1);
    run(4'ha, 1, 1);
    mw(8'h03);
    ev(6'h04);
    check(16'(srq), 16'h0);
    do_poll();
    check(16'(pb), 16'h04);
    ev(6'h02);
    check(16'(srq), 16'h1);
    ev(6'h08);
    do_poll();
    check(16'(pb), 16'h42);
    check(16'(srq), 16'h0);
    for (int k = 0; k < 6; k++) begin
      mw(8'h01 << k);
      ev(6'h01 << k);
      check(16'(srq), 16'h1);
      do_poll();
      check(16'(pb), 16'h40 | (16'h1 << k));
    end
    mw(8'h00);
    ev(6'h3f);
    check(16'(srq), 16'h0);
    do_poll();
    check(16'(pb), 16'h3f);
    $display("status tests done");
    mw(8'h3f);
    @(posedge clk);
    dclr <= 1;
    @(posedge clk);
    dclr <= 0;
    ev(6'h20);
    check(16'(srq), 16'h0);
    do_poll();
    run(4'h0, 0, 0);
    complete_run();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
